// File: rtl/afh_fault_handler.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module afh_fault_handler
  import afh_pkg::*;
#(
  parameter int NUM_AXES = AFH_MAX_AXES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic [7:0]                  addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [31:0]                 rdata,
  input  wire afh_axis_in_t [NUM_AXES-1:0] axis_in,
  input  wire logic                        slave_fault,
  input  wire logic [AFH_NODE_W-1:0]       slave_fault_node,
  input  wire afh_nvm_t                    nvm,
  input  wire logic                        op_req,
  input  wire logic                        op_is_param,
  output logic                             op_accept,
  output logic                             op_refuse,
  output logic                             params_valid,
  output logic      [NUM_AXES-1:0]         servo_lock,
  output logic      [NUM_AXES-1:0]         axis_stop,
  output logic      [NUM_AXES-1:0]         stop_immediate,
  output afh_disp_t                        two_char_code_display,
  output logic                             unit_error_led,
  output logic                             irq
);

  if (NUM_AXES < 1 || NUM_AXES > AFH_MAX_AXES) begin : g_bad_axes
    $error("NUM_AXES out of range");
  end

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire wr_ctrl   = wr_en && (addr == AFH_REG_CTRL);
  wire wr_lock   = wr_en && (addr == AFH_REG_LOCK);
  wire wr_eslog  = wr_en && (addr == AFH_REG_ESTOP_LOG);
  wire wr_fwdlog = wr_en && (addr == AFH_REG_FWD_LOG);
  wire wr_revlog = wr_en && (addr == AFH_REG_REV_LOG);
  wire wr_stopm  = wr_en && (addr == AFH_REG_STOP_MTHD);
  wire wr_irqclr = wr_en && (addr == AFH_REG_IRQ_CLR);
  wire wr_irqen  = wr_en && (addr == AFH_REG_IRQ_EN);

  logic [NUM_AXES-1:0]  lock_req_ff;
  logic                 estop_log_ff;
  logic [NUM_AXES-1:0]  fwd_log_ff;
  logic [NUM_AXES-1:0]  rev_log_ff;
  logic [NUM_AXES-1:0]  stop_mthd_ff;
  logic [AFH_EVT_W-1:0] irq_stat_ff;
  logic [AFH_EVT_W-1:0] irq_en_ff;
  logic [31:0]          rdata_ff;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lock_req_ff  <= AFH_RST_LOCK[NUM_AXES-1:0];
      estop_log_ff <= AFH_RST_ESTOP_LOG;
      fwd_log_ff   <= AFH_RST_LIM_LOG[NUM_AXES-1:0];
      rev_log_ff   <= AFH_RST_LIM_LOG[NUM_AXES-1:0];
      stop_mthd_ff <= AFH_RST_STOP_MTHD[NUM_AXES-1:0];
      irq_en_ff    <= AFH_RST_EVT;
    end else begin
      if (wr_lock)   lock_req_ff  <= wdata[NUM_AXES-1:0];
      if (wr_eslog)  estop_log_ff <= wdata[0];
      if (wr_fwdlog) fwd_log_ff   <= wdata[NUM_AXES-1:0];
      if (wr_revlog) rev_log_ff   <= wdata[NUM_AXES-1:0];
      if (wr_stopm)  stop_mthd_ff <= wdata[NUM_AXES-1:0];
      if (wr_irqen)  irq_en_ff    <= wdata[AFH_EVT_W-1:0];
    end
  end

  // ****************************************************************
  // memory error and parameter validity
  // ****************************************************************
  logic mem_err_ff;
  logic params_valid_ff;
  logic first_check_ff;
  logic op_accept_ff;
  logic op_refuse_ff;

  wire mem_fault     = (nvm.save_done && nvm.save_bad) || (nvm.check_done && nvm.check_bad);
  wire mem_good      = (nvm.save_done && !nvm.save_bad) || (nvm.check_done && !nvm.check_bad);
  wire nxt_mem_err   = mem_fault || (mem_err_ff && !mem_good);
  wire nxt_pvalid    = !(first_check_ff && nvm.check_done && nvm.check_bad)
                       && (mem_good || params_valid_ff);
  wire err_rst       = wr_ctrl && wdata[AFH_CTRL_ERR_RST_BIT] && !mem_err_ff;
  wire op_ok         = op_req && (op_is_param || !mem_err_ff);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mem_err_ff      <= 1'b0;
      params_valid_ff <= 1'b0;
      first_check_ff  <= 1'b1;
      op_accept_ff    <= 1'b0;
      op_refuse_ff    <= 1'b0;
    end else begin
      mem_err_ff      <= nxt_mem_err;
      params_valid_ff <= nxt_pvalid;
      if (nvm.check_done) first_check_ff <= 1'b0;
      op_accept_ff    <= op_ok;
      op_refuse_ff    <= op_req && !op_ok;
    end
  end

  // ****************************************************************
  // slave communications error
  // ****************************************************************
  logic                  comm_err_ff;
  logic [AFH_NODE_W-1:0] comm_node_ff;

  wire node_ok  = (slave_fault_node >= AFH_NODE_MIN) && (slave_fault_node <= AFH_NODE_MAX);
  wire comm_set = slave_fault && node_ok && !comm_err_ff;
  wire comm_clr = err_rst && !slave_fault;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      comm_err_ff  <= 1'b0;
      comm_node_ff <= '0;
    end else begin
      comm_err_ff <= comm_set || (comm_err_ff && !comm_clr);
      if (comm_set) comm_node_ff <= slave_fault_node;
    end
  end

  // ****************************************************************
  // per-axis detection
  // ****************************************************************
  logic [NUM_AXES-1:0] err_estop_ff;
  logic [NUM_AXES-1:0] err_fwd_ff;
  logic [NUM_AXES-1:0] err_rev_ff;
  logic [NUM_AXES-1:0] err_alarm_ff;
  logic [NUM_AXES-1:0] err_main_ff;
  logic [NUM_AXES-1:0] prev_estop_ff;
  logic [NUM_AXES-1:0] prev_fwd_ff;
  logic [NUM_AXES-1:0] prev_rev_ff;
  logic [NUM_AXES-1:0] servo_lock_ff;
  logic [NUM_AXES-1:0] axis_stop_ff;
  logic [NUM_AXES-1:0] estop_act;
  logic [NUM_AXES-1:0] fwd_act;
  logic [NUM_AXES-1:0] rev_act;
  logic [NUM_AXES-1:0] main_set;

  genvar a;
  generate
    for (a = 0; a < NUM_AXES; a++) begin : g_axis
      assign estop_act[a] = axis_in[a].estop == estop_log_ff;
      assign fwd_act[a]   = axis_in[a].fwd_lim == fwd_log_ff[a];
      assign rev_act[a]   = axis_in[a].rev_lim == rev_log_ff[a];
      assign main_set[a]  = !axis_in[a].main_pwr_on && servo_lock_ff[a];

      wire estop_set = estop_act[a] && !prev_estop_ff[a];
      wire fwd_set   = fwd_act[a] && !prev_fwd_ff[a];
      wire rev_set   = rev_act[a] && !prev_rev_ff[a];
      wire nxt_lock  = lock_req_ff[a] && !mem_err_ff && !err_estop_ff[a]
                       && !err_alarm_ff[a] && !estop_set && !axis_in[a].drv_alarm;

      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          prev_estop_ff[a] <= 1'b0;
          prev_fwd_ff[a]   <= 1'b0;
          prev_rev_ff[a]   <= 1'b0;
          err_estop_ff[a]  <= 1'b0;
          err_fwd_ff[a]    <= 1'b0;
          err_rev_ff[a]    <= 1'b0;
          err_alarm_ff[a]  <= 1'b0;
          err_main_ff[a]   <= 1'b0;
          servo_lock_ff[a] <= 1'b0;
          axis_stop_ff[a]  <= 1'b0;
        end else begin
          prev_estop_ff[a] <= estop_act[a];
          prev_fwd_ff[a]   <= fwd_act[a];
          prev_rev_ff[a]   <= rev_act[a];
          // set wins over reset; reset only with the cause gone
          err_estop_ff[a] <= estop_set
                             || (err_estop_ff[a] && !(err_rst && !estop_act[a]));
          err_fwd_ff[a]   <= fwd_set || (err_fwd_ff[a] && !(err_rst && !fwd_act[a]));
          err_rev_ff[a]   <= rev_set || (err_rev_ff[a] && !(err_rst && !rev_act[a]));
          err_alarm_ff[a] <= axis_in[a].drv_alarm
                             || (err_alarm_ff[a] && !err_rst);
          err_main_ff[a]  <= main_set[a]
                             || (err_main_ff[a] && !(err_rst && axis_in[a].main_pwr_on));
          servo_lock_ff[a] <= nxt_lock;
          axis_stop_ff[a]  <= fwd_set || rev_set
                              || err_fwd_ff[a] || err_rev_ff[a];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // display code, unit error, interrupt
  // ****************************************************************
  wire [NUM_AXES-1:0] axis_err = err_estop_ff | err_fwd_ff | err_rev_ff
                                 | err_alarm_ff | err_main_ff;
  logic [7:0] first_axis;

  always_comb begin
    first_axis = 8'h00;
    for (int i = NUM_AXES - 1; i >= 0; i--) begin
      if (axis_err[i]) first_axis = 8'(i + 1);
    end
  end

  wire afh_disp_t nxt_disp =
      mem_err_ff  ? afh_disp_t'{code: AFH_CODE_MEM,  num: 8'h00} :
      comm_err_ff ? afh_disp_t'{code: AFH_CODE_AXIS, num: {1'b0, comm_node_ff}} :
      |axis_err   ? afh_disp_t'{code: AFH_CODE_AXIS, num: first_axis} :
                    afh_disp_t'{code: AFH_CODE_NONE, num: 8'h00};

  wire [NUM_AXES-1:0] alarm_raw;
  wire [NUM_AXES-1:0] alarm_rise = alarm_raw & ~err_alarm_ff;
  for (genvar j = 0; j < NUM_AXES; j++) begin : g_alarm
    assign alarm_raw[j] = axis_in[j].drv_alarm;
  end

  wire [AFH_EVT_W-1:0] evt_now;
  assign evt_now[AFH_EVT_MEM]   = mem_fault;
  assign evt_now[AFH_EVT_COMM]  = comm_set;
  assign evt_now[AFH_EVT_MAIN]  = |(main_set & ~err_main_ff);
  assign evt_now[AFH_EVT_ESTOP] = |(estop_act & ~prev_estop_ff);
  assign evt_now[AFH_EVT_FWD]   = |(fwd_act & ~prev_fwd_ff);
  assign evt_now[AFH_EVT_REV]   = |(rev_act & ~prev_rev_ff);
  assign evt_now[AFH_EVT_ALARM] = |alarm_rise;

  wire [AFH_EVT_W-1:0] irq_clr = wr_irqclr ? wdata[AFH_EVT_W-1:0] : '0;
  wire [AFH_EVT_W-1:0] nxt_stat = evt_now | (irq_stat_ff & ~irq_clr);

  afh_disp_t disp_ff;
  logic      unit_err_ff;
  logic      irq_ff;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      disp_ff     <= '{code: AFH_CODE_NONE, num: 8'h00};
      unit_err_ff <= 1'b0;
      irq_stat_ff <= AFH_RST_EVT;
      irq_ff      <= 1'b0;
    end else begin
      disp_ff     <= nxt_disp;
      unit_err_ff <= mem_err_ff || comm_err_ff || |axis_err;
      irq_stat_ff <= nxt_stat;
      irq_ff      <= |(nxt_stat & irq_en_ff);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  function automatic logic [31:0] afh_ext(input logic [NUM_AXES-1:0] v);
    afh_ext = 32'(v);
  endfunction

  wire [31:0] unit_stat = {13'h0000, comm_err_ff, params_valid_ff, mem_err_ff, disp_ff};
  wire [31:0] rd_mux =
      (addr == AFH_REG_LOCK)      ? afh_ext(lock_req_ff) :
      (addr == AFH_REG_ESTOP_LOG) ? {31'h00000000, estop_log_ff} :
      (addr == AFH_REG_FWD_LOG)   ? afh_ext(fwd_log_ff) :
      (addr == AFH_REG_REV_LOG)   ? afh_ext(rev_log_ff) :
      (addr == AFH_REG_STOP_MTHD) ? afh_ext(stop_mthd_ff) :
      (addr == AFH_REG_IRQ_STAT)  ? 32'(irq_stat_ff) :
      (addr == AFH_REG_IRQ_EN)    ? 32'(irq_en_ff) :
      (addr == AFH_REG_ERR_ESTOP) ? afh_ext(err_estop_ff) :
      (addr == AFH_REG_ERR_FWD)   ? afh_ext(err_fwd_ff) :
      (addr == AFH_REG_ERR_REV)   ? afh_ext(err_rev_ff) :
      (addr == AFH_REG_ERR_ALARM) ? afh_ext(err_alarm_ff) :
      (addr == AFH_REG_ERR_MAIN)  ? afh_ext(err_main_ff) :
      (addr == AFH_REG_UNIT_STAT) ? unit_stat : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!rstn) rdata_ff <= 32'h00000000;
    else       rdata_ff <= rd_en ? rd_mux : 32'h00000000;
  end

  assign rdata                 = rdata_ff;
  assign op_accept             = op_accept_ff;
  assign op_refuse             = op_refuse_ff;
  assign params_valid          = params_valid_ff;
  assign servo_lock            = servo_lock_ff;
  assign axis_stop             = axis_stop_ff;
  assign stop_immediate        = stop_mthd_ff;
  assign two_char_code_display = disp_ff;
  assign unit_error_led        = unit_err_ff;
  assign irq                   = irq_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_mem_code_shown: assert property (mem_err_ff |=> disp_ff.code == AFH_CODE_MEM)
    else $error("memory error not shown as E9");
  a_mem_op_refused: assert property (op_req && !op_is_param && mem_err_ff
                                     |=> op_refuse && !op_accept)
    else $error("operation accepted during memory error");
  a_boot_params_unset: assert property (first_check_ff && nvm.check_done && nvm.check_bad
                                        |=> !params_valid_ff)
    else $error("corrupt parameters applied at power-up");
  a_comm_code_node: assert property (comm_err_ff && !mem_err_ff
                                     |=> disp_ff.code == AFH_CODE_AXIS
                                         && disp_ff.num == {1'b0, $past(comm_node_ff)})
    else $error("communications error code wrong");
  a_main_circuit: assert property (main_set[NUM_AXES-1]
    |=> err_main_ff[NUM_AXES-1] ##1 unit_error_led)
    else $error("main circuit error not raised");
  a_estop_unlock: assert property (estop_act[0] && !prev_estop_ff[0]
                                   |=> err_estop_ff[0] && !servo_lock_ff[0])
    else $error("emergency stop did not unlock servo");
  a_estop_level: assert property ((axis_in[0].estop != estop_log_ff) && !err_estop_ff[0]
                                  |=> !err_estop_ff[0])
    else $error("inactive emergency stop level raised error");
  a_fwd_stop: assert property (fwd_act[0] && !prev_fwd_ff[0]
                               |=> err_fwd_ff[0] && axis_stop_ff[0])
    else $error("forward limit did not stop axis");
  a_rev_stop: assert property (rev_act[NUM_AXES-1] && !prev_rev_ff[NUM_AXES-1]
    |=> err_rev_ff[NUM_AXES-1] && axis_stop_ff[NUM_AXES-1])
    else $error("reverse limit did not stop axis");
  a_alarm_unlock: assert property (axis_in[NUM_AXES-1].drv_alarm
    |=> err_alarm_ff[NUM_AXES-1] ##1 !servo_lock_ff[NUM_AXES-1])
    else $error("drive alarm did not unlock servo");
  a_estop_held: assert property (err_estop_ff[0] && estop_act[0] |=> err_estop_ff[0])
    else $error("emergency stop error cleared while input active");
  a_error_latched: assert property (err_fwd_ff[0] && !err_rst |=> err_fwd_ff[0])
    else $error("limit error dropped without reset");

  c_estop_reset: cover property (err_estop_ff[0] ##[1:20] !err_estop_ff[0]);
  c_mem_recover: cover property (mem_err_ff ##[1:50] params_valid_ff);
  c_comm_irq:    cover property (comm_set ##[1:5] irq);

endmodule

// File: rtl/afh_pkg.sv
package afh_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int          AFH_MAX_AXES   = 16;
  localparam int          AFH_NODE_W     = 7;
  localparam logic [6:0]  AFH_NODE_MIN   = 7'h01;
  localparam logic [6:0]  AFH_NODE_MAX   = 7'h50;
  localparam int          AFH_EVT_W      = 7;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0]  AFH_REG_CTRL      = 8'h00;
  localparam logic [7:0]  AFH_REG_LOCK      = 8'h04;
  localparam logic [7:0]  AFH_REG_ESTOP_LOG = 8'h08;
  localparam logic [7:0]  AFH_REG_FWD_LOG   = 8'h0C;
  localparam logic [7:0]  AFH_REG_REV_LOG   = 8'h10;
  localparam logic [7:0]  AFH_REG_STOP_MTHD = 8'h14;
  localparam logic [7:0]  AFH_REG_IRQ_STAT  = 8'h18;
  localparam logic [7:0]  AFH_REG_IRQ_CLR   = 8'h1C;
  localparam logic [7:0]  AFH_REG_IRQ_EN    = 8'h20;
  localparam logic [7:0]  AFH_REG_ERR_ESTOP = 8'h24;
  localparam logic [7:0]  AFH_REG_ERR_FWD   = 8'h28;
  localparam logic [7:0]  AFH_REG_ERR_REV   = 8'h2C;
  localparam logic [7:0]  AFH_REG_ERR_ALARM = 8'h30;
  localparam logic [7:0]  AFH_REG_ERR_MAIN  = 8'h34;
  localparam logic [7:0]  AFH_REG_UNIT_STAT = 8'h38;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AFH_CTRL_ERR_RST_BIT = 0;
  localparam int AFH_UST_MEM_BIT      = 16;
  localparam int AFH_UST_PVALID_BIT   = 17;
  localparam int AFH_UST_COMM_BIT     = 18;
  localparam int AFH_EVT_MEM          = 0;
  localparam int AFH_EVT_COMM         = 1;
  localparam int AFH_EVT_MAIN         = 2;
  localparam int AFH_EVT_ESTOP        = 3;
  localparam int AFH_EVT_FWD          = 4;
  localparam int AFH_EVT_REV          = 5;
  localparam int AFH_EVT_ALARM        = 6;

  // ****************************************************************
  // reset values and display codes
  // ****************************************************************
  localparam logic        AFH_RST_ESTOP_LOG = 1'b0;
  localparam logic [15:0] AFH_RST_LIM_LOG   = 16'h0000;
  localparam logic [15:0] AFH_RST_STOP_MTHD = 16'h0000;
  localparam logic [15:0] AFH_RST_LOCK      = 16'h0000;
  localparam logic [6:0]  AFH_RST_EVT       = 7'h00;
  localparam logic [7:0]  AFH_CODE_MEM      = 8'hE9;
  localparam logic [7:0]  AFH_CODE_AXIS     = 8'hAE;
  localparam logic [7:0]  AFH_CODE_NONE     = 8'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic estop;
    logic fwd_lim;
    logic rev_lim;
    logic drv_alarm;
    logic main_pwr_on;
  } afh_axis_in_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] num;
  } afh_disp_t;

  typedef struct packed {
    logic check_done;
    logic check_bad;
    logic save_done;
    logic save_bad;
  } afh_nvm_t;

endpackage

// File: tb/afh_drive_model.sv
`timescale 1ns/1ps
module afh_drive_model
  import afh_pkg::*;
#(
  parameter int N = 2
) (
  input  wire logic                 sys_clk,
  input  wire afh_axis_in_t [N-1:0] want_axis,
  input  wire logic [7:0]           want_node,
  input  wire afh_nvm_t             want_nvm,
  output afh_axis_in_t [N-1:0]      axis_in,
  output logic                      slave_fault,
  output logic [AFH_NODE_W-1:0]     slave_fault_node,
  output afh_nvm_t                  nvm
);
  // drives and slaves answer one edge after the host asks; main power idles on
  initial begin
    axis_in          = {N{5'b11101}};
    slave_fault      = 1'b0;
    slave_fault_node = 7'h00;
    nvm              = 4'h0;
  end
  always @(posedge sys_clk) begin
    axis_in          <= want_axis;
    slave_fault      <= (want_node != 8'h00);
    // node field is not held once the fault is gone
    slave_fault_node <= (want_node != 8'h00) ? want_node[6:0] : ~slave_fault_node;
    nvm              <= want_nvm;
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb
  import afh_pkg::*;
;
  typedef struct {
    logic [4:0] mask;
    logic [7:0] adr;
    int         evt;
    logic [1:0] lock;
    logic [1:0] stop;
  } afh_row_t;
  localparam afh_axis_in_t IDLE = 5'b11101;
  afh_row_t rows [5] = '{
    '{5'b10000, AFH_REG_ERR_ESTOP, AFH_EVT_ESTOP, 2'b01, 2'b00},
    '{5'b01000, AFH_REG_ERR_FWD,   AFH_EVT_FWD,   2'b11, 2'b10},
    '{5'b00100, AFH_REG_ERR_REV,   AFH_EVT_REV,   2'b11, 2'b10},
    '{5'b00010, AFH_REG_ERR_ALARM, AFH_EVT_ALARM, 2'b01, 2'b00},
    '{5'b00001, AFH_REG_ERR_MAIN,  AFH_EVT_MAIN,  2'b11, 2'b00}};
  logic sys_clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, op_req = 1'b0, op_is_param = 1'b0;
  logic [7:0] addr = 8'h00, want_node = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  afh_axis_in_t [1:0] want_axis = {IDLE, IDLE}, axis_in;
  afh_nvm_t want_nvm = 4'h0, nvm;
  logic slave_fault, op_accept, op_refuse, params_valid, unit_error_led, irq;
  logic [6:0] slave_fault_node;
  logic [1:0] servo_lock, axis_stop, stop_immediate;
  afh_disp_t two_char_code_display;
  int n_errors = 0, compares = 0, cycles = 0;

  afh_drive_model #(.N(2)) afh_drive_model_inst (.sys_clk(sys_clk), .want_axis(want_axis),
    .want_node(want_node), .want_nvm(want_nvm), .axis_in(axis_in), .slave_fault(slave_fault),
    .slave_fault_node(slave_fault_node), .nvm(nvm));
  afh_fault_handler #(.NUM_AXES(2)) afh_fault_handler_inst (.sys_clk(sys_clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .axis_in(axis_in), .slave_fault(slave_fault), .slave_fault_node(slave_fault_node),
    .nvm(nvm), .op_req(op_req), .op_is_param(op_is_param), .op_accept(op_accept),
    .op_refuse(op_refuse), .params_valid(params_valid), .servo_lock(servo_lock),
    .axis_stop(axis_stop), .stop_immediate(stop_immediate),
    .two_char_code_display(two_char_code_display), .unit_error_led(unit_error_led), .irq(irq));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  // ****************************************************************
  // bus and check helpers
  // ****************************************************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rc(string what, logic [7:0] a, logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  task automatic op(logic p, logic [1:0] e);
    @(posedge sys_clk);
    op_req <= 1'b1; op_is_param <= p;
    @(posedge sys_clk);
    op_req <= 1'b0;
    #1 chk("op answer", {30'h0, e}, {30'h0, op_accept, op_refuse});
  endtask
  task automatic nv(logic [3:0] v);
    @(posedge sys_clk);
    want_nvm <= v;
    @(posedge sys_clk);
    want_nvm <= 4'h0;
    tick(3);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    tick(20);
    rstn <= 1'b1;
    nv(4'b1100);
    chk("params valid", 0, params_valid);
    chk("mem code", AFH_CODE_MEM, two_char_code_display.code);
    op(1'b0, 2'b01);
    op(1'b1, 2'b10);
    wr(AFH_REG_CTRL, 32'h1);
    tick(2);
    chk("mem held", AFH_CODE_MEM, two_char_code_display.code);
    nv(4'b0010);
    chk("params valid", 1, params_valid);
    $display("memory test done");
    wr(AFH_REG_LOCK, 32'h3);
    wr(AFH_REG_IRQ_EN, 32'h7F);
    wr(AFH_REG_STOP_MTHD, 32'h2);
    tick(2);
    chk("stop method", 2'b10, stop_immediate);
    rc("unmapped", 8'hFC, 32'h0);
    chk("mem irq", 1, irq);
    rc("mem event", AFH_REG_IRQ_STAT, 32'h1 << AFH_EVT_MEM);
    wr(AFH_REG_IRQ_CLR, 32'h7F);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      want_axis[1] <= IDLE ^ rows[i].mask;
      tick(4);
      chk("servo lock", rows[i].lock, servo_lock);
      chk("axis stop", rows[i].stop, axis_stop);
      chk("display", {AFH_CODE_AXIS, 8'h02}, two_char_code_display);
      chk("led irq", 2'b11, {unit_error_led, irq});
      rc("error bits", rows[i].adr, 32'h2);
      rc("irq status", AFH_REG_IRQ_STAT, 32'h1 << rows[i].evt);
      @(posedge sys_clk);
      want_axis[1] <= IDLE;
      tick(3);
      wr(AFH_REG_CTRL, 32'h1);
      wr(AFH_REG_IRQ_CLR, 32'h7F);
      tick(2);
      rc("error cleared", rows[i].adr, 32'h0);
      chk("restored", {2'b00, 2'b11, 2'b00}, {irq, unit_error_led, servo_lock, axis_stop});
      $display("axis event row %0d done", i);
    end
    @(posedge sys_clk);
    want_node <= 8'h51;
    tick(4);
    chk("node out of range", 16'h0, two_char_code_display);
    want_node <= 8'h50;
    tick(4);
    rc("unit status", AFH_REG_UNIT_STAT, 32'h0006AE50);
    want_node <= 8'h00;
    tick(2);
    wr(AFH_REG_CTRL, 32'h1);
    tick(2);
    chk("comm cleared", 16'h0, two_char_code_display);
    $display("comm test done");
    wr(AFH_REG_IRQ_EN, 32'h0);
    want_axis[0] <= IDLE ^ 5'b10000;
    tick(4);
    wr(AFH_REG_CTRL, 32'h1);
    tick(2);
    rc("estop held", AFH_REG_ERR_ESTOP, 32'h1);
    chk("irq masked", 0, irq);
    want_axis[0] <= IDLE;
    wr(AFH_REG_ESTOP_LOG, 32'h1);
    wr(AFH_REG_FWD_LOG, 32'h1);
    tick(4);
    rc("fwd by logic", AFH_REG_ERR_FWD, 32'h1);
    rc("rev untouched", AFH_REG_ERR_REV, 32'h0);
    wr(AFH_REG_IRQ_EN, 32'h7F);
    tick(2);
    chk("irq unmasked", 1, irq);
    want_axis <= {IDLE ^ 5'b10000, 5'b00101};
    tick(3);
    wr(AFH_REG_CTRL, 32'h1);
    wr(AFH_REG_IRQ_CLR, 32'h7F);
    tick(2);
    rc("estop by logic", AFH_REG_ERR_ESTOP, 32'h0);
    chk("all clear", 2'b00, {irq, unit_error_led});
    $display("logic test done");
    test_done();
  end
endmodule
